// ==== adc_ctrl_pkg.sv ====
// Package for the successive-approximation converter control unit.
// Holds register offsets, bit positions, reset values and timing counts.
`default_nettype none
package adc_ctrl_pkg;
  // Register byte offsets on the 20-bit internal address space.
  localparam logic [19:0] ADDR_RESULT_A_HIGH = 20'hFFFE0;
  localparam logic [19:0] ADDR_RESULT_A_LOW = 20'hFFFE1;
  localparam logic [19:0] ADDR_RESULT_B_HIGH = 20'hFFFE2;
  localparam logic [19:0] ADDR_RESULT_B_LOW = 20'hFFFE3;
  localparam logic [19:0] ADDR_RESULT_C_HIGH = 20'hFFFE4;
  localparam logic [19:0] ADDR_RESULT_C_LOW = 20'hFFFE5;
  localparam logic [19:0] ADDR_RESULT_D_HIGH = 20'hFFFE6;
  localparam logic [19:0] ADDR_RESULT_D_LOW = 20'hFFFE7;
  localparam logic [19:0] ADDR_CTRL_STATUS = 20'hFFFE8;
  localparam logic [19:0] ADDR_TRIGGER_CTRL = 20'hFFFE9;
  // Field positions in the control/status register.
  localparam int END_FLAG_BIT = 7;
  localparam int IRQ_ENABLE_BIT = 6;
  localparam int START_BIT = 5;
  localparam int SCAN_BIT = 4;
  localparam int TIME_SEL_BIT = 3;
  localparam int GROUP_BIT = 2;
  // Field positions in the trigger control register.
  localparam int TRIG_ENABLE_BIT = 7;
  localparam int TRIG_SPARE_BIT = 0;
  // Reset values.
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] TRIGGER_CTRL_RESET = 8'h7E;
  localparam logic [7:0] TRIGGER_FIXED_ONES = 8'h7E;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  // Conversion time limits in states (clock cycles).
  localparam int SLOW_CONV_STATES = 134;
  localparam int FAST_CONV_STATES = 70;
  localparam logic [7:0] SLOW_CONV_CYCLES = 8'(SLOW_CONV_STATES);
  localparam logic [7:0] FAST_CONV_CYCLES = 8'(FAST_CONV_STATES);
  // Conversion sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_LAUNCH,
    SEQ_WAIT
  } seq_state_e;
endpackage
`default_nettype wire

// ==== adc_ctrl_unit.sv ====
// Control and register logic of a 10-bit successive-approximation converter.
// Assumes an 8-bit synchronous CPU bus with one-cycle read/write strobes and an
// analog core that answers each start strobe with a done pulse and a result.
//
// Functional notes
// - Result high byte upper eight, low two at top.
// - Result bits five down to zero read zero.
// - Channels n and n+4 share register n.
// - Results cleared on reset and standby.
// - High byte direct, low byte through latch.
// - High read copies low byte into latch.
// - Control/status cleared on reset and standby.
// - End flag set at single or scan end.
// - End flag cleared by zero after read.
// - DMA acknowledge also clears the end flag.
// - Interrupt request gated by interrupt enable.
// - Start set by software, trigger, timer.
// - Start bit stays one while converting.
// - Single mode clears start at completion.
// - Scan repeats until start bit cleared.
// - Scan starts at group first, wraps around.
// - Mode bit selects single or scan.
// - Time select limits conversion to 134/70.
// - Single mode uses group and channel bits.
// - Scan converts one to four channels.
// - End request offered as DMA activation.
// - Trigger enable gates external and timer starts.
`default_nettype none
module adc_ctrl_unit (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic standby,
  input wire logic [19:0] bus_addr,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic external_trigger_input,
  input wire logic timer_compare_match,
  input wire logic dma_ack,
  output logic conversion_end_irq,
  output logic dma_request,
  output logic core_start,
  output logic [2:0] core_channel,
  output logic core_time_select,
  output logic [7:0] core_time_limit,
  input wire logic core_done,
  input wire logic [9:0] core_result
);

  // Control/status fields held separately.
  logic conversion_end_flag_reg;
  logic end_irq_enable_reg;
  logic conversion_start_bit_reg;
  logic scan_mode_reg;
  logic conversion_time_select_reg;
  logic [2:0] channel_sel_reg;
  // Trigger control: enable bit and the writable spare bit.
  logic trigger_enable_bit_reg;
  logic trig_spare_reg;
  // Four 10-bit results and the low-byte latch.
  logic [9:0] result_mem [4];
  logic [7:0] low_latch_reg;
  // Armed when software has read the end flag as one.
  logic flag_seen_reg;
  // Previous trigger pin level for falling-edge detection.
  logic trig_prev_reg;
  // Sequencer state, current position within the scan and cycle counter.
  adc_ctrl_pkg::seq_state_e seq_reg;
  logic [1:0] scan_pos_reg;
  logic [7:0] conv_cnt_reg;
  logic [7:0] read_data_next;

  // Packs a 10-bit result into a high or low byte of its 16-bit register.
  function automatic logic [7:0] result_byte(input logic [9:0] res, input logic low);
    result_byte = low ? {res[1:0], 6'h00} : res[9:2];
  endfunction

  // Decoded accesses.
  logic csr_wr;
  logic trg_wr;
  logic csr_rd;
  logic is_result;
  logic [1:0] res_index;
  logic res_low;
  assign csr_wr = bus_wr && (bus_addr == adc_ctrl_pkg::ADDR_CTRL_STATUS);
  assign trg_wr = bus_wr && (bus_addr == adc_ctrl_pkg::ADDR_TRIGGER_CTRL);
  assign csr_rd = bus_rd && (bus_addr == adc_ctrl_pkg::ADDR_CTRL_STATUS);
  assign is_result = (bus_addr >= adc_ctrl_pkg::ADDR_RESULT_A_HIGH) &&
                     (bus_addr <= adc_ctrl_pkg::ADDR_RESULT_D_LOW);
  assign res_index = bus_addr[2:1];
  assign res_low = bus_addr[0];

  // Qualified start events from the pin and the timer.
  logic trig_fall;
  logic hw_start;
  assign trig_fall = trig_prev_reg && !external_trigger_input;
  assign hw_start = trigger_enable_bit_reg && (trig_fall || timer_compare_match);

  // Selected channel count minus one in scan mode, and completion signals.
  logic last_in_scan;
  logic conv_done;
  logic [1:0] first_chan;
  assign last_in_scan = scan_pos_reg == channel_sel_reg[1:0];
  // A done pulse that arrives after an abort is neither stored nor flagged.
  assign conv_done = (seq_reg == adc_ctrl_pkg::SEQ_WAIT) && core_done && conversion_start_bit_reg;

  logic end_event;
  assign end_event = conv_done && (!scan_mode_reg || last_in_scan);
  assign first_chan = 2'h0;

  // Trigger pin history; an idle pin is high.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trig_prev_reg <= 1'b1;
    end else begin
      trig_prev_reg <= external_trigger_input;
    end
  end

  // Control/status bits other than the flag and the start bit.
  // reset and standby clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      end_irq_enable_reg <= 1'b0;
      scan_mode_reg <= 1'b0;
      conversion_time_select_reg <= 1'b0;
      channel_sel_reg <= 3'h0;
    end else if (standby) begin
      end_irq_enable_reg <= 1'b0;
      scan_mode_reg <= 1'b0;
      conversion_time_select_reg <= 1'b0;
      channel_sel_reg <= 3'h0;
    end else if (csr_wr) begin
      end_irq_enable_reg <= bus_wdata[adc_ctrl_pkg::IRQ_ENABLE_BIT];
      scan_mode_reg <= bus_wdata[adc_ctrl_pkg::SCAN_BIT];
      conversion_time_select_reg <= bus_wdata[adc_ctrl_pkg::TIME_SEL_BIT];
      channel_sel_reg <= bus_wdata[2:0];
    end
  end

  // Trigger control register; bits 6..1 are fixed ones. Standby restores reset value.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trigger_enable_bit_reg <= 1'b0;
      trig_spare_reg <= 1'b0;
    end else if (standby) begin
      trigger_enable_bit_reg <= 1'b0;
      trig_spare_reg <= 1'b0;
    end else if (trg_wr) begin
      trigger_enable_bit_reg <= bus_wdata[adc_ctrl_pkg::TRIG_ENABLE_BIT];
      trig_spare_reg <= bus_wdata[adc_ctrl_pkg::TRIG_SPARE_BIT];
    end
  end

  // End flag: hardware set wins over a DMA or software clear in the same cycle; standby wins over the set.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      conversion_end_flag_reg <= 1'b0;
      flag_seen_reg <= 1'b0;
    end else if (standby) begin
      conversion_end_flag_reg <= 1'b0;
      flag_seen_reg <= 1'b0;
    end else if (end_event) begin
      conversion_end_flag_reg <= 1'b1;
      flag_seen_reg <= 1'b0;
    end else if (dma_ack && dma_request) begin
      conversion_end_flag_reg <= 1'b0;
      flag_seen_reg <= 1'b0;
    end else if (csr_wr && flag_seen_reg && !bus_wdata[adc_ctrl_pkg::END_FLAG_BIT]) begin
      conversion_end_flag_reg <= 1'b0;
      flag_seen_reg <= 1'b0;
    end else if (csr_rd && conversion_end_flag_reg) begin
      flag_seen_reg <= 1'b1;
    end
  end

  // Start bit: set by software or hardware starts, held during conversion.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      conversion_start_bit_reg <= 1'b0;
    end else if (standby) begin
      conversion_start_bit_reg <= 1'b0;
    end else if (csr_wr) begin
      conversion_start_bit_reg <= bus_wdata[adc_ctrl_pkg::START_BIT];
    end else if (hw_start) begin
      conversion_start_bit_reg <= 1'b1;
    end else if (conv_done && !scan_mode_reg) begin
      conversion_start_bit_reg <= 1'b0;
    end
  end

  // Conversion sequencer; a cleared start bit aborts whatever is in flight.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seq_reg <= adc_ctrl_pkg::SEQ_IDLE;
      scan_pos_reg <= 2'h0;
      conv_cnt_reg <= 8'h00;
    end else if (standby || !conversion_start_bit_reg) begin
      seq_reg <= adc_ctrl_pkg::SEQ_IDLE;
      scan_pos_reg <= 2'h0;
      conv_cnt_reg <= 8'h00;
    end else begin
      case (seq_reg)
        adc_ctrl_pkg::SEQ_IDLE: begin
          scan_pos_reg <= first_chan;
          seq_reg <= adc_ctrl_pkg::SEQ_LAUNCH;
        end
        adc_ctrl_pkg::SEQ_LAUNCH: begin
          conv_cnt_reg <= 8'h00;
          seq_reg <= adc_ctrl_pkg::SEQ_WAIT;
        end
        adc_ctrl_pkg::SEQ_WAIT: begin
          conv_cnt_reg <= conv_cnt_reg + 8'h01;
          if (core_done) begin
            if (scan_mode_reg) begin
              scan_pos_reg <= last_in_scan ? first_chan : scan_pos_reg + 2'h1;
              seq_reg <= adc_ctrl_pkg::SEQ_LAUNCH;
            end else begin
              seq_reg <= adc_ctrl_pkg::SEQ_IDLE;
            end
          end
        end
        default: begin
          seq_reg <= adc_ctrl_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Core interface: channel from mode, strobe from the launch state.
  // scan or single channel choice
  assign core_channel = scan_mode_reg ? {channel_sel_reg[adc_ctrl_pkg::GROUP_BIT], scan_pos_reg}
                                      : channel_sel_reg;
  assign core_start = seq_reg == adc_ctrl_pkg::SEQ_LAUNCH;
  assign core_time_select = conversion_time_select_reg;
  assign core_time_limit = conversion_time_select_reg ? adc_ctrl_pkg::FAST_CONV_CYCLES
                                                      : adc_ctrl_pkg::SLOW_CONV_CYCLES;

  // Result storage; channel low two bits pick the register.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        result_mem[i] <= adc_ctrl_pkg::RESULT_RESET[9:0];
      end
    end else if (standby) begin
      for (int i = 0; i < 4; i++) begin
        result_mem[i] <= adc_ctrl_pkg::RESULT_RESET[9:0];
      end
    end else if (conv_done && conversion_start_bit_reg) begin
      result_mem[core_channel[1:0]] <= core_result;
    end
  end

  // Low-byte latch loaded on every high-byte read.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      low_latch_reg <= 8'h00;
    end else if (standby) begin
      low_latch_reg <= 8'h00;
    end else if (bus_rd && is_result && !res_low) begin
      low_latch_reg <= result_byte(result_mem[res_index], 1'b1);
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    read_data_next = 8'h00;
    if (is_result) begin
      read_data_next = res_low ? low_latch_reg : result_byte(result_mem[res_index], 1'b0);
    end else if (bus_addr == adc_ctrl_pkg::ADDR_CTRL_STATUS) begin
      read_data_next = {conversion_end_flag_reg, end_irq_enable_reg, conversion_start_bit_reg,
                        scan_mode_reg, conversion_time_select_reg, channel_sel_reg};
    end else if (bus_addr == adc_ctrl_pkg::ADDR_TRIGGER_CTRL) begin
      read_data_next = adc_ctrl_pkg::TRIGGER_FIXED_ONES |
                       {trigger_enable_bit_reg, 6'h00, trig_spare_reg};
    end
  end

  // Read data registered one cycle after the read strobe.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata <= read_data_next;
    end
  end

  assign conversion_end_irq = conversion_end_flag_reg && end_irq_enable_reg;
  assign dma_request = conversion_end_irq;

  // A conversion end with the enable set raises the request one cycle later.
  irq_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
    (end_event && end_irq_enable_reg && !csr_wr && !standby) |=> conversion_end_irq)
    else $error("interrupt not raised at conversion end");

  // Completed single conversion drops the start bit next cycle.
  single_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (conv_done && !scan_mode_reg && !csr_wr && !hw_start && !standby) |=> !conversion_start_bit_reg)
    else $error("single mode start bit not cleared");

  // End event raises the flag next cycle.
  flag_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    (end_event && !standby) |=> conversion_end_flag_reg)
    else $error("end flag not set");

  // Writing one cannot set the flag.
  flag_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!conversion_end_flag_reg && !end_event) |=> !conversion_end_flag_reg)
    else $error("end flag set without conversion end");

  // Standby clears control/status and results.
  standby_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    standby |=> (!conversion_start_bit_reg && !end_irq_enable_reg && result_mem[0] == 10'h000))
    else $error("standby did not clear state");

  // Disabled trigger never starts a conversion.
  trig_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!conversion_start_bit_reg && !trigger_enable_bit_reg && !csr_wr) |=> !conversion_start_bit_reg)
    else $error("start without enabled trigger");

  // Scan channel always stays within the selected count.
  scan_range_a: assert property (@(posedge mclk) disable iff (!resetn)
    (scan_mode_reg && seq_reg == adc_ctrl_pkg::SEQ_WAIT) |-> scan_pos_reg <= channel_sel_reg[1:0])
    else $error("scan channel out of range");

  // High-byte read loads the latch with the packed low byte.
  latch_copy_a: assert property (@(posedge mclk) disable iff (!resetn)
    (bus_rd && is_result && !res_low && !standby) |=>
      low_latch_reg == {$past(result_mem[0][1:0]), 6'h00} || $past(res_index) != 2'h0)
    else $error("low byte latch not loaded");

  // Launch strobe is followed by the wait state.
  launch_wait_a: assert property (@(posedge mclk) disable iff (!resetn)
    (core_start && conversion_start_bit_reg && !standby) |=> seq_reg == adc_ctrl_pkg::SEQ_WAIT)
    else $error("launch not followed by wait");

  // A conversion never runs past the limit announced to the core; a slow core shows here.
  conv_limit_a: assert property (@(posedge mclk) disable iff (!resetn)
    (seq_reg == adc_ctrl_pkg::SEQ_WAIT) |-> (conv_cnt_reg <= core_time_limit))
    else $error("conversion exceeded its time limit");

  // An accepted DMA transfer clears the flag unless a new end arrives with it.
  dma_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    (dma_ack && dma_request && !end_event && !standby) |=> !conversion_end_flag_reg)
    else $error("end flag not cleared by DMA");

endmodule
`default_nettype wire

// ==== adc_core_model.sv ====
// Behavioural model of the analog input multiplexer and successive-approximation core.
// Assumes the control unit pulses core_start for one cycle and holds core_channel meanwhile.
`default_nettype none
module adc_core_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic core_start,
  input wire logic [2:0] core_channel,
  input wire logic [7:0] core_time_limit,
  input wire logic [7:0] delay,
  input wire logic [9:0] base,
  output logic core_done,
  output logic [9:0] core_result
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cycles left in the running conversion; zero while idle.
  logic [7:0] cnt_reg;
  // The bench chooses the length, but it never exceeds the limit the unit announces.
  // Outside the done pulse the result lines toggle, so a late or early sample is caught.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 8'h00;
      core_done <= 1'b0;
      core_result <= 10'h000;
    end else begin
      core_done <= 1'b0;
      core_result <= ~core_result;
      if (core_start) begin
        cnt_reg <= (delay < core_time_limit) ? delay : core_time_limit;
      end else if (cnt_reg == 8'h01) begin
        // The result depends on the channel, so a wrong register pairing shows.
        cnt_reg <= 8'h00;
        core_done <= 1'b1;
        core_result <= base + {7'h00, core_channel};
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sar_adc_control_unit_tb_top.sv ====
// Self-checking bench for the converter control unit with a behavioural core beside it.
// Assumes the package constants and a one-cycle read/write strobe bus.
`default_nettype none
module sar_adc_control_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [19:0] CS = adc_ctrl_pkg::ADDR_CTRL_STATUS;
  localparam logic [19:0] TC = adc_ctrl_pkg::ADDR_TRIGGER_CTRL;
  logic mclk = 1'b0, resetn = 1'b0, standby = 1'b0, bus_rd = 1'b0, bus_wr = 1'b0;
  logic [19:0] bus_addr = 20'h00000;
  logic [7:0] bus_wdata = 8'h00, bus_rdata, core_time_limit, delay = 8'h05, d;
  logic ext_trig = 1'b1, timer_hit = 1'b0, dma_ack = 1'b0, irq, dma_req, core_start, tsel, core_done;
  logic [2:0] core_channel;
  logic [9:0] core_result, base = 10'h000;
  logic [9:0] exp_res [4];
  logic [31:0] seed = 32'h00018607;
  int err_total = 0, total_checks = 0, cyc = 0, i, k;
  logic ie, fast_sel;
  always #2.5 mclk = ~mclk;
  adc_ctrl_unit u_dut (.mclk(mclk), .resetn(resetn), .standby(standby), .bus_addr(bus_addr),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .external_trigger_input(ext_trig), .timer_compare_match(timer_hit), .dma_ack(dma_ack),
    .conversion_end_irq(irq), .dma_request(dma_req), .core_start(core_start),
    .core_channel(core_channel), .core_time_select(tsel), .core_time_limit(core_time_limit),
    .core_done(core_done), .core_result(core_result));
  adc_core_model u_core (.mclk(mclk), .resetn(resetn), .core_start(core_start),
    .core_channel(core_channel), .core_time_limit(core_time_limit), .delay(delay), .base(base),
    .core_done(core_done), .core_result(core_result));
  // Next value of the repeatable xorshift sequence.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // Upper byte of a stored result: the eight high bits.
  function automatic logic [7:0] hi_of(input logic [9:0] v);
    return v[9:2];
  endfunction
  // Lower byte: two low bits at the top, the rest zero.
  function automatic logic [7:0] lo_of(input logic [9:0] v);
    return {v[1:0], 6'h00};
  endfunction
  // One comparison; a mismatch is printed and counted at once.
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bus read: strobe for one cycle, data is taken the cycle after.
  task automatic rd(input logic [19:0] a, output logic [7:0] v);
    @(posedge mclk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask
  // Bus write: strobe for one cycle; the write lands at that edge.
  task automatic wr(input logic [19:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge mclk);
    bus_wr <= 1'b0;
    #1;
  endtask
  // Poll the status register until the start bit drops, with a bounded count.
  task automatic wait_idle();
    for (k = 0; k < 200; k++) begin
      rd(CS, d);
      if (d[adc_ctrl_pkg::START_BIT] === 1'b0) break;
    end
  endtask
  // Both bytes of all four result registers against the bench's own record.
  task automatic chk_res();
    logic [7:0] v;
    for (k = 0; k < 4; k++) begin
      rd(adc_ctrl_pkg::ADDR_RESULT_A_HIGH + 20'(2 * k), v);
      chk("result high", 10'(hi_of(exp_res[k])), 10'(v));
      rd(adc_ctrl_pkg::ADDR_RESULT_A_LOW + 20'(2 * k), v);
      chk("result low", 10'(lo_of(exp_res[k])), 10'(v));
    end
  endtask
  // Prints the counts and the verdict; the only place where the run ends.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // A hang is cut short well above the several hundred cycles the sequence needs.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    // Reset values of every register, and an unmapped address reading zero.
    for (i = 0; i < 11; i++) begin
      rd(adc_ctrl_pkg::ADDR_RESULT_A_HIGH + 20'(i), d);
      chk("reset value", (i == 9) ? 10'h07E : 10'h000, 10'(d));
    end
    // Results start cleared, so registers not yet converted are expected to read zero.
    for (i = 0; i < 4; i++) exp_res[i] = 10'h000;
    // Single mode on every channel with random value, length, enable and speed.
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      base <= seed[9:0];
      delay <= {3'h0, seed[14:10]} + 8'h02;
      ie = seed[16];
      fast_sel = seed[17];
      exp_res[i % 4] = seed[9:0] + 10'(i);
      wr(CS, {1'b0, ie, 1'b1, 1'b0, fast_sel, 3'(i)});
      chk("time select", 10'(fast_sel), 10'(tsel));
      chk("time limit", fast_sel ? 10'h046 : 10'h086, 10'(core_time_limit));
      rd(CS, d);
      chk("start held", 10'h001, 10'(d[adc_ctrl_pkg::START_BIT]));
      wait_idle();
      chk("end flag", 10'h001, 10'(d[adc_ctrl_pkg::END_FLAG_BIT]));
      chk("irq", 10'(ie), 10'(irq));
      chk("dma request", 10'(ie), 10'(dma_req));
      chk_res();
      wr(CS, 8'h80);
      rd(CS, d);
      chk("flag after one", 10'h001, 10'(d[adc_ctrl_pkg::END_FLAG_BIT]));
      wr(CS, 8'h00);
      rd(CS, d);
      chk("flag cleared", 10'h000, 10'(d));
    end
    // Scan of three channels in the upper group; runs on past the end flag.
    seed = xs(seed);
    base <= seed[9:0];
    delay <= 8'h05;
    for (i = 0; i < 3; i++) exp_res[i] = seed[9:0] + 10'(i + 4);
    wr(CS, 8'h76);
    for (i = 0; i < 100; i++) begin
      rd(CS, d);
      if (d[adc_ctrl_pkg::END_FLAG_BIT] === 1'b1) break;
    end
    chk("scan end flag", 10'h001, 10'(d[adc_ctrl_pkg::END_FLAG_BIT]));
    chk("scan keeps start", 10'h001, 10'(d[adc_ctrl_pkg::START_BIT]));
    chk("scan irq", 10'h001, 10'(irq));
    wr(CS, 8'h00);
    repeat (20) @(posedge mclk);
    chk_res();
    // External trigger falling edge, then a timer match, both enabled.
    wr(TC, 8'h80);
    rd(TC, d);
    chk("trigger control", 10'h0FE, 10'(d));
    seed = xs(seed);
    base <= seed[9:0];
    exp_res[0] = seed[9:0];
    wr(CS, 8'h40);
    @(posedge mclk);
    ext_trig <= 1'b0;
    rd(CS, d);
    ext_trig <= 1'b1;
    chk("trigger start", 10'h001, 10'(d[adc_ctrl_pkg::START_BIT]));
    wait_idle();
    chk("irq before dma", 10'h001, 10'(irq));
    @(posedge mclk);
    dma_ack <= 1'b1;
    @(posedge mclk);
    dma_ack <= 1'b0;
    #1;
    chk("dma clears flag", 10'h000, 10'(irq));
    @(posedge mclk);
    timer_hit <= 1'b1;
    @(posedge mclk);
    timer_hit <= 1'b0;
    rd(CS, d);
    chk("timer start", 10'h001, 10'(d[adc_ctrl_pkg::START_BIT]));
    wait_idle();
    chk_res();
    // With the trigger enable off, a timer match is ignored.
    wr(CS, 8'h00);
    wr(TC, 8'h00);
    @(posedge mclk);
    timer_hit <= 1'b1;
    @(posedge mclk);
    timer_hit <= 1'b0;
    rd(CS, d);
    chk("timer ignored", 10'h000, 10'(d[adc_ctrl_pkg::START_BIT]));
    // Standby clears results and both control registers.
    wr(TC, 8'h81);
    @(posedge mclk);
    standby <= 1'b1;
    @(posedge mclk);
    standby <= 1'b0;
    rd(TC, d);
    chk("standby trigger", 10'h07E, 10'(d));
    rd(CS, d);
    chk("standby status", 10'h000, 10'(d));
    for (i = 0; i < 4; i++) exp_res[i] = 10'h000;
    chk_res();
    end_of_test();
  end
endmodule
`default_nettype wire
